// ===== hw/lnl_pkg.sv
// holds the constants shared by the network record loader host
// assumes a 50 MHz system clock and an apb master on the software side
package lnl_pkg;

  // ----------------------------------------------------------------
  // apb register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [11:0] LNL_CTRL_OFS = 12'h000;
  localparam logic [11:0] LNL_STAT_OFS = 12'h004;
  localparam logic [11:0] LNL_NET_OFS = 12'h008;
  localparam logic [11:0] LNL_CFG_BASE = 12'h100;
  localparam logic [11:0] LNL_CELL_BASE = 12'h200;
  localparam logic [11:0] LNL_OFLD_OFS = 12'h300;
  localparam logic [11:0] LNL_OVAL_OFS = 12'h304;
  localparam logic [11:0] LNL_ORST_OFS = 12'h308;
  localparam logic [11:0] LNL_OSEC_OFS = 12'h30c;
  localparam logic [11:0] LNL_OMODE_OFS = 12'h310;

  // control and status bit positions
  localparam int LNL_CTRL_SEND_CFG = 0;
  localparam int LNL_CTRL_SEND_NET = 1;
  localparam int LNL_STAT_BUSY = 0;
  localparam int LNL_STAT_DONE = 1;
  localparam int LNL_STAT_ERR = 2;

  // ----------------------------------------------------------------
  // record layout
  // ----------------------------------------------------------------
  localparam logic [7:0] LNL_CFG_REC = 8'hcb;
  localparam logic [7:0] LNL_NET_REC = 8'hd8;
  localparam int LNL_LINES = 6;
  localparam int LNL_COLS = 5;
  localparam int LNL_IN_CELLS = LNL_LINES * LNL_COLS;
  localparam int LNL_REC_BYTES = 68;
  localparam int LNL_REC_WORDS = LNL_REC_BYTES / 2;
  localparam int LNL_OUT_BITS = 64;
  localparam int LNL_VAL_W = LNL_OUT_BITS - 16 * 3 - 8;
  localparam int LNL_CFG_SLOTS = 22;

  // cell field positions
  localparam int LNL_NUM_LSB = 0;
  localparam int LNL_TYPE_LSB = 8;
  localparam int LNL_OR_BIT = 10;
  localparam int LNL_FB_BIT = 11;
  localparam int LNL_FUNC_LSB = 12;
  localparam logic [3:0] LNL_OTYPE_PHYS = 4'h8;
  localparam logic [3:0] LNL_OTYPE_XREG = 4'hb;
  localparam logic [3:0] LNL_FUNC_BAD = 4'hf;
  localparam logic [3:0] LNL_SYM_LAST = 4'h3;

  // reset values
  localparam logic [15:0] LNL_WORD_RST = 16'h0000;

  typedef enum logic [1:0] {LNL_SRC_NONE, LNL_SRC_CFG, LNL_SRC_NET} lnl_src_t;

  // data word number that each configuration slot carries
  function automatic logic [7:0] lnl_cfg_word(input logic [4:0] slot);
    case (slot)
      5'h08: lnl_cfg_word = 8'h0a;
      5'h09: lnl_cfg_word = 8'h0b;
      5'h0a: lnl_cfg_word = 8'h1e;
      5'h0b: lnl_cfg_word = 8'h1f;
      5'h0c: lnl_cfg_word = 8'h2d;
      5'h0d: lnl_cfg_word = 8'h2e;
      5'h0e: lnl_cfg_word = 8'h2f;
      5'h0f: lnl_cfg_word = 8'h30;
      5'h10: lnl_cfg_word = 8'h31;
      5'h11: lnl_cfg_word = 8'h32;
      5'h12: lnl_cfg_word = 8'h33;
      5'h13: lnl_cfg_word = 8'h34;
      5'h14: lnl_cfg_word = 8'h40;
      5'h15: lnl_cfg_word = 8'h41;
      default: lnl_cfg_word = {3'h0, slot};
    endcase
  endfunction : lnl_cfg_word

endpackage : lnl_pkg

// ===== hw/lnl_sync.sv
// two flip-flop synchroniser for one pin level
// assumes the pin is asynchronous to sys_clk_i
`timescale 1ns/10ps
module lnl_sync
  import lnl_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // level in and out
  input wire logic async_i,
  output logic sync_o
);

  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : lnl_sync

// ===== hw/lnl_cell_check.sv
// checks every cell of a staged network record for illegal codes
// assumes the cells are stable while the result is used
`timescale 1ns/10ps
module lnl_cell_check
  import lnl_pkg::*;
#(
  parameter int CELLS = LNL_IN_CELLS
)
(
  // staged record
  input wire logic [CELLS*16-1:0] cells_i,
  input wire logic [15:0] out_field_i,
  // verdict
  output logic bad_o
);

  logic [CELLS-1:0] cell_bad;
  logic [3:0] otype;
  logic [3:0] ofunc;

  genvar g;
  generate
    for (g = 0; g < CELLS; g++)
    begin : g_cell
      // only empty, conduction, open and closed symbols exist
      assign cell_bad[g] = cells_i[g*16+LNL_FUNC_LSB +: 4] > LNL_SYM_LAST;
    end
  endgenerate

  assign otype = out_field_i[LNL_TYPE_LSB +: 4];
  assign ofunc = out_field_i[LNL_FUNC_LSB +: 4];

  assign bad_o = (|cell_bad)
    || (otype < LNL_OTYPE_PHYS) || (otype > LNL_OTYPE_XREG)
    || (ofunc == LNL_FUNC_BAD);

endmodule : lnl_cell_check

// ===== hw/lnl_host.sv
// host that stages configuration words and network records from apb and
// sends them word by word to the logic module over a four-phase link
// assumes the device answers every word with a level ack on its own clock
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps

// Notes on behaviour
// - path words 0-7, gear words 10, 11
// - cam switch input 30, output 31
// - run select 45, inputs 46, outputs 47
// - resource words 48-52, shift 64, 65
// - logic built from same configuration values
// - network words travel in record 216
// - each input cell one 16-bit word
// - 64-bit output cell follows input cells
// - whole 68-byte record, never partial
// - output cell field order fixed
// - output type codes 8 to 11 only
// - function code 15 is invalid
// - input cell number, type, feedback bit
// - OR bit and symbols 0 to 3
module lnl_host
  import lnl_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // word link to the logic module
  output logic lnk_req_o,
  output logic [7:0] lnk_rec_o,
  output logic [7:0] lnk_net_o,
  output logic [7:0] lnk_idx_o,
  output logic [15:0] lnk_data_o,
  output logic lnk_first_o,
  output logic lnk_last_o,
  input wire logic lnk_ack_i
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] cfg_ff [LNL_CFG_SLOTS];
  logic [15:0] cell_ff [LNL_IN_CELLS];
  logic [15:0] ofld_ff;
  logic [LNL_VAL_W-1:0] oval_ff;
  logic [15:0] orst_ff;
  logic [15:0] osec_ff;
  logic [7:0] omode_ff;
  logic [7:0] net_ff;
  logic done_ff;
  logic err_ff;

  typedef enum logic [1:0] {LNL_IDLE, LNL_REQ, LNL_DROP} lnl_state_t;
  lnl_state_t state_ff;
  lnl_src_t src_ff;
  logic [5:0] cnt_ff;
  logic [5:0] last_idx;
  logic ack_s;

  logic wr_acc;
  logic rd_acc;
  logic hit_cfg;
  logic hit_cell;
  logic [4:0] cfg_slot;
  logic [4:0] cell_idx;
  logic mapped;
  logic busy;
  logic start_cfg;
  logic start_net;
  logic net_bad;
  logic [LNL_OUT_BITS-1:0] out_cell;
  logic [LNL_IN_CELLS*16-1:0] cells_flat;
  logic [15:0] word_mux;
  logic [1:0] oslice;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_acc = psel_i && !pwrite_i;
  assign cfg_slot = paddr_i[6:2];
  assign cell_idx = paddr_i[6:2];
  assign hit_cfg = (paddr_i[11:7] == LNL_CFG_BASE[11:7]) && (paddr_i[1:0] == 2'h0)
    && (cfg_slot < 5'(LNL_CFG_SLOTS));
  assign hit_cell = (paddr_i[11:7] == LNL_CELL_BASE[11:7]) && (paddr_i[1:0] == 2'h0)
    && (cell_idx < 5'(LNL_IN_CELLS));
  assign busy = (state_ff != LNL_IDLE);

  always_comb
  begin
    case (paddr_i)
      LNL_CTRL_OFS, LNL_STAT_OFS, LNL_NET_OFS, LNL_OFLD_OFS, LNL_OVAL_OFS,
      LNL_ORST_OFS, LNL_OSEC_OFS, LNL_OMODE_OFS: mapped = 1'b1;
      default: mapped = hit_cfg || hit_cell;
    endcase
  end

  // zero wait states; unmapped addresses answer with an error
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      prdata_o <= 32'h0000_0000;
    else if (rd_acc && !penable_i)
    begin
      if (hit_cfg)
        prdata_o <= {16'h0000, cfg_ff[cfg_slot]};
      else if (hit_cell)
        prdata_o <= {16'h0000, cell_ff[cell_idx]};
      else
      begin
        case (paddr_i)
          LNL_STAT_OFS: prdata_o <= {23'h0, cnt_ff, 3'h0} | {29'h0, err_ff, done_ff, busy};
          LNL_NET_OFS: prdata_o <= {24'h0, net_ff};
          LNL_OFLD_OFS: prdata_o <= {16'h0000, ofld_ff};
          LNL_OVAL_OFS: prdata_o <= {{(32 - LNL_VAL_W){1'b0}}, oval_ff};
          LNL_ORST_OFS: prdata_o <= {16'h0000, orst_ff};
          LNL_OSEC_OFS: prdata_o <= {16'h0000, osec_ff};
          LNL_OMODE_OFS: prdata_o <= {24'h0, omode_ff};
          default: prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // staging registers
  // ----------------------------------------------------------------
  // staging is frozen while a send runs so no block goes out half old
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < LNL_CFG_SLOTS; i++)
        cfg_ff[i] <= LNL_WORD_RST;
    end
    else if (wr_acc && hit_cfg && !busy)
      cfg_ff[cfg_slot] <= pwdata_i[15:0];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < LNL_IN_CELLS; i++)
        cell_ff[i] <= LNL_WORD_RST;
    end
    else if (wr_acc && hit_cell && !busy)
      cell_ff[cell_idx] <= pwdata_i[15:0];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ofld_ff <= LNL_WORD_RST;
      oval_ff <= '0;
      orst_ff <= LNL_WORD_RST;
      osec_ff <= LNL_WORD_RST;
      omode_ff <= 8'h00;
      net_ff <= 8'h00;
    end
    else if (wr_acc && !busy)
    begin
      case (paddr_i)
        LNL_OFLD_OFS: ofld_ff <= pwdata_i[15:0];
        // only the low value bits fit the output cell
        LNL_OVAL_OFS: oval_ff <= pwdata_i[LNL_VAL_W-1:0];
        LNL_ORST_OFS: orst_ff <= pwdata_i[15:0];
        LNL_OSEC_OFS: osec_ff <= pwdata_i[15:0];
        LNL_OMODE_OFS: omode_ff <= pwdata_i[7:0];
        LNL_NET_OFS: net_ff <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // record assembly and checks
  // ----------------------------------------------------------------
  assign out_cell = {omode_ff, osec_ff, orst_ff, oval_ff, ofld_ff};

  genvar g;
  generate
    for (g = 0; g < LNL_IN_CELLS; g++)
    begin : g_flat
      assign cells_flat[g*16 +: 16] = cell_ff[g];
    end
  endgenerate

  lnl_cell_check #(
    .CELLS(LNL_IN_CELLS)
  ) u_check (
    .cells_i(cells_flat),
    .out_field_i(ofld_ff),
    .bad_o(net_bad)
  );

  // slice number wraps in two bits, so it never reaches past the output cell
  assign oslice = cnt_ff[1:0] - 2'(LNL_IN_CELLS);

  // grid first, line by line, then the output cell in 16-bit slices
  always_comb
  begin
    if (cnt_ff < 6'(LNL_IN_CELLS))
      word_mux = cell_ff[cnt_ff[4:0]];
    else
      word_mux = out_cell[oslice * 16 +: 16];
  end

  // ----------------------------------------------------------------
  // send sequencer
  // ----------------------------------------------------------------
  lnl_sync u_ack_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i(lnk_ack_i),
    .sync_o(ack_s)
  );

  assign start_cfg = wr_acc && (paddr_i == LNL_CTRL_OFS) && pwdata_i[LNL_CTRL_SEND_CFG];
  assign start_net = wr_acc && (paddr_i == LNL_CTRL_OFS) && pwdata_i[LNL_CTRL_SEND_NET]
    && !pwdata_i[LNL_CTRL_SEND_CFG];
  assign last_idx = (src_ff == LNL_SRC_CFG) ? 6'(LNL_CFG_SLOTS - 1) : 6'(LNL_REC_WORDS - 1);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= LNL_IDLE;
      src_ff <= LNL_SRC_NONE;
      cnt_ff <= 6'h00;
    end
    else
    begin
      case (state_ff)
        LNL_IDLE:
        begin
          cnt_ff <= 6'h00;
          if (start_cfg)
          begin
            src_ff <= LNL_SRC_CFG;
            state_ff <= LNL_REQ;
          end
          // an invalid record is never started, so nothing partial leaves
          else if (start_net && !net_bad)
          begin
            src_ff <= LNL_SRC_NET;
            state_ff <= LNL_REQ;
          end
        end
        LNL_REQ:
          if (ack_s)
            state_ff <= LNL_DROP;
        LNL_DROP:
          if (!ack_s)
          begin
            if (cnt_ff == last_idx)
            begin
              state_ff <= LNL_IDLE;
              src_ff <= LNL_SRC_NONE;
            end
            else
            begin
              cnt_ff <= cnt_ff + 6'h01;
              state_ff <= LNL_REQ;
            end
          end
        default: state_ff <= LNL_IDLE;
      endcase
    end
  end

  // done and error are sticky; write one to clear, a new event wins
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      done_ff <= 1'b0;
      err_ff <= 1'b0;
    end
    else
    begin
      if (state_ff == LNL_DROP && !ack_s && cnt_ff == last_idx)
        done_ff <= 1'b1;
      else if (wr_acc && paddr_i == LNL_STAT_OFS && pwdata_i[LNL_STAT_DONE])
        done_ff <= 1'b0;
      if (!busy && start_net && net_bad)
        err_ff <= 1'b1;
      else if (wr_acc && paddr_i == LNL_STAT_OFS && pwdata_i[LNL_STAT_ERR])
        err_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // link outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      lnk_rec_o <= 8'h00;
      lnk_idx_o <= 8'h00;
      lnk_data_o <= 16'h0000;
      lnk_first_o <= 1'b0;
      lnk_last_o <= 1'b0;
      lnk_net_o <= 8'h00;
    end
    else if (src_ff == LNL_SRC_CFG)
    begin
      // the same staged words the logic was built against go out here
      lnk_rec_o <= LNL_CFG_REC;
      lnk_idx_o <= lnl_cfg_word(cnt_ff[4:0]);
      lnk_data_o <= cfg_ff[cnt_ff[4:0]];
      lnk_first_o <= (cnt_ff == 6'h00);
      lnk_last_o <= (cnt_ff == last_idx);
    end
    else if (src_ff == LNL_SRC_NET)
    begin
      lnk_rec_o <= LNL_NET_REC;
      lnk_net_o <= net_ff;
      lnk_idx_o <= {2'h0, cnt_ff};
      lnk_data_o <= word_mux;
      lnk_first_o <= (cnt_ff == 6'h00);
      // the device starts the network on this marker alone
      lnk_last_o <= (cnt_ff == last_idx);
    end
  end

  // request is raised on the same edge that loads the word registers
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      lnk_req_o <= 1'b0;
    else
      lnk_req_o <= (state_ff == LNL_REQ) && !ack_s;
  end

endmodule : lnl_host

// ===== verification/lnl_host_asserts.sv
// concurrent checks on the ports of the network record loader host
// assumes it is bound to lnl_host and that lnl_pkg is compiled first
`timescale 1ns/10ps
module lnl_host_chk
  import lnl_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // word link
  input wire logic lnk_req_o,
  input wire logic [7:0] lnk_rec_o,
  input wire logic [7:0] lnk_idx_o,
  input wire logic [15:0] lnk_data_o,
  input wire logic lnk_first_o,
  input wire logic lnk_last_o,
  input wire logic lnk_ack_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // ack passes two flops, so the drop may lag the pin by up to four edges
  sequence ack_seen;
    lnk_req_o && lnk_ack_i;
  endsequence
  sequence req_gone;
    ##[1:4] !lnk_req_o;
  endsequence

  ready_high_a: assert property (pready_o) else $error("pready low");
  err_unmapped_a: assert property (psel_i && penable_i && paddr_i == 12'h0fc |-> pslverr_o)
    else $error("no error on unmapped address");
  err_access_a: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error outside access phase");
  req_hold_a: assert property (lnk_req_o && !lnk_ack_i |=> lnk_req_o)
    else $error("request dropped before ack");
  req_drop_a: assert property (ack_seen |-> req_gone)
    else $error("request held after ack");
  word_stable_a: assert property (lnk_req_o && $past(lnk_req_o) |->
    $stable(lnk_data_o) && $stable(lnk_idx_o) && $stable(lnk_rec_o))
    else $error("word changed under request");
  ack_low_a: assert property ($rose(lnk_req_o) |-> !lnk_ack_i && !$past(lnk_ack_i))
    else $error("request raised before ack low");
  rec_code_a: assert property (lnk_req_o |->
    lnk_rec_o == LNL_CFG_REC || lnk_rec_o == LNL_NET_REC) else $error("bad record number");
  first_idx_a: assert property (lnk_req_o && lnk_first_o |-> lnk_idx_o == 8'h00)
    else $error("block does not start at word 0");
  net_last_a: assert property (lnk_req_o && lnk_last_o && lnk_rec_o == LNL_NET_REC |->
    lnk_idx_o == 8'h21) else $error("network block not 34 words");
  cfg_last_a: assert property (lnk_req_o && lnk_last_o && lnk_rec_o == LNL_CFG_REC |->
    lnk_idx_o == 8'h41) else $error("config block ends on wrong word");
  net_range_a: assert property (lnk_req_o && lnk_rec_o == LNL_NET_REC |->
    lnk_idx_o < 8'h22) else $error("network word index out of range");
endmodule : lnl_host_chk

bind lnl_host lnl_host_chk i_lnl_host_chk (.sys_clk_i, .rst_i, .psel_i, .penable_i, .paddr_i,
  .pready_o, .pslverr_o, .lnk_req_o, .lnk_rec_o, .lnk_idx_o, .lnk_data_o, .lnk_first_o,
  .lnk_last_o, .lnk_ack_i);

// ===== verification/lnl_dev_model.sv
// behavioural logic module on the far side of the host word link
// assumes four-phase requests; ack comes delay_i + 1 edges after the request
`timescale 1ns/10ps
module lnl_dev_model
  import lnl_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // word link
  input wire logic req_i,
  input wire logic [7:0] rec_i,
  input wire logic [7:0] net_i,
  input wire logic [7:0] idx_i,
  input wire logic [15:0] data_i,
  input wire logic last_i,
  input wire logic [3:0] delay_i,
  output logic ack_o
);
  logic [3:0] wait_ff;
  logic [15:0] cfg_mem [0:127];
  logic [15:0] net_mem [0:33];
  logic [7:0] run_net_ff;
  logic run_ff;
  int word_cnt;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !req_i)
    begin
      ack_o <= 1'b0;
      wait_ff <= 4'h0;
    end
    else if (!ack_o)
    begin
      wait_ff <= wait_ff + 4'h1;
      ack_o <= wait_ff >= delay_i;
    end
  end

  // words are taken at the edge that raises ack
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      run_ff <= 1'b0;
      word_cnt <= 0;
    end
    else if (req_i && !ack_o && wait_ff >= delay_i)
    begin
      word_cnt <= word_cnt + 1;
      if (rec_i == LNL_CFG_REC)
        cfg_mem[idx_i[6:0]] <= data_i;
      else
        net_mem[idx_i] <= data_i;
      if (rec_i == LNL_NET_REC && last_i)
      begin
        run_ff <= 1'b1;
        run_net_ff <= net_i;
      end
    end
  end
endmodule : lnl_dev_model

// ===== verification/lnl_host_tb.sv
// self-checking bench for the network record loader host
// assumes lnl_pkg, the design, the checker and the model are compiled first
`timescale 1ns/10ps
module lnl_host_tb
  import lnl_pkg::*;
;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} lnl_row_t;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] delay_i = 4'h0;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, lnk_req_o, lnk_first_o, lnk_last_o, lnk_ack_i, err;
  logic [7:0] lnk_rec_o, lnk_net_o, lnk_idx_o;
  logic [15:0] lnk_data_o;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int n0;
  int cfg_words [22] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11, 30, 31, 45, 46, 47, 48, 49, 50, 51, 52, 64,
    65};
  lnl_row_t rows [6] = '{
    '{LNL_NET_OFS, 32'h0000_12a5, 32'h0000_00a5, 1'b0},
    '{LNL_CFG_BASE, 32'hffff_beef, 32'h0000_beef, 1'b0},
    '{LNL_CELL_BASE + 12'h074, 32'h0000_3fff, 32'h0000_3fff, 1'b0},
    '{LNL_OVAL_OFS, 32'h1234_5678, 32'h0000_0078, 1'b0},
    '{LNL_OMODE_OFS, 32'h0000_0302, 32'h0000_0002, 1'b0},
    '{12'h0fc, 32'h0000_0001, 32'h0000_0000, 1'b1}};
  logic [11:0] bad_a [3] = '{LNL_CELL_BASE + 12'h00c, LNL_OFLD_OFS, LNL_OFLD_OFS};
  logic [31:0] bad_d [3] = '{32'h0000_4000, 32'h0000_f806, 32'h0000_0706};
  logic [31:0] good_d [3] = '{32'h0000_2104, 32'h0000_0806, 32'h0000_0806};

  initial
  begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  lnl_host i_lnl_host (.sys_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .lnk_req_o, .lnk_rec_o, .lnk_net_o, .lnk_idx_o,
    .lnk_data_o, .lnk_first_o, .lnk_last_o, .lnk_ack_i);
  lnl_dev_model i_lnl_dev_model (.sys_clk_i, .rst_i, .req_i(lnk_req_o), .rec_i(lnk_rec_o),
    .net_i(lnk_net_o), .idx_i(lnk_idx_o), .data_i(lnk_data_o), .last_i(lnk_last_o), .delay_i,
    .ack_o(lnk_ack_i));

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do
      @(posedge sys_clk_i);
    while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wait_done();
    do
      apb(1'b0, LNL_STAT_OFS, 32'h0);
    while (rd[LNL_STAT_BUSY] !== 1'b0);
  endtask : wait_done

  // output cell packs {mode, second, reset, value low byte, field}, low slice first
  task automatic send_net(input logic [3:0] dly, input logic [7:0] net);
    logic [63:0] oc;
    oc = {8'h02, 16'h1234, 16'h0000, 8'h64, 16'h0806};
    delay_i <= dly;
    apb(1'b1, LNL_NET_OFS, {24'h0, net});
    for (int i = 0; i < 30; i++)
      apb(1'b1, LNL_CELL_BASE + 12'(4 * i), {16'h0, 8'h21, 8'(net + i)});
    apb(1'b1, LNL_OFLD_OFS, 32'h0000_0806);
    apb(1'b1, LNL_OVAL_OFS, 32'h0001_0064);
    apb(1'b1, LNL_ORST_OFS, 32'h0);
    apb(1'b1, LNL_OSEC_OFS, 32'h0000_1234);
    apb(1'b1, LNL_OMODE_OFS, 32'h0000_0002);
    apb(1'b1, LNL_CTRL_OFS, 32'h0000_0002);
    wait_done();
    for (int i = 0; i < 30; i++)
      chk(i_lnl_dev_model.net_mem[i], {16'h0, 8'h21, 8'(net + i)});
    for (int i = 0; i < 4; i++)
      chk(i_lnl_dev_model.net_mem[30 + i], oc[16 * i +: 16]);
    chk(i_lnl_dev_model.run_ff, 1'b1);
    chk(i_lnl_dev_model.run_net_ff, net);
    $display("test network %0d done", net);
  endtask : send_net

  // hang guard well above the roughly 1400 cycles the tests take
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      results();
    end
  end

  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    apb(1'b0, LNL_STAT_OFS, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[r])
    begin
      apb(1'b1, rows[r].a, rows[r].d);
      apb(1'b0, rows[r].a, 32'h0);
      chk(rd, rows[r].q);
      chk(err, rows[r].e);
    end
    $display("test registers done");
    for (int s = 0; s < 22; s++)
      apb(1'b1, LNL_CFG_BASE + 12'(4 * s), 32'h0000_c000 + s);
    apb(1'b1, LNL_CTRL_OFS, 32'h0000_0001);
    wait_done();
    chk(rd[LNL_STAT_DONE], 1'b1);
    foreach (cfg_words[s])
      chk(i_lnl_dev_model.cfg_mem[cfg_words[s]], 32'h0000_c000 + s);
    $display("test config done");
    send_net(4'h0, 8'h01);
    for (int b = 0; b < 3; b++)
    begin
      n0 = i_lnl_dev_model.word_cnt;
      apb(1'b1, bad_a[b], bad_d[b]);
      apb(1'b1, LNL_CTRL_OFS, 32'h0000_0002);
      wait_done();
      chk(rd[LNL_STAT_ERR], 1'b1);
      chk(i_lnl_dev_model.word_cnt, n0);
      apb(1'b1, LNL_STAT_OFS, 32'h0000_0006);
      apb(1'b1, bad_a[b], good_d[b]);
    end
    apb(1'b0, LNL_STAT_OFS, 32'h0);
    chk(rd[2:1], 2'b00);
    $display("test invalid cells done");
    rst_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    chk(i_lnl_dev_model.run_ff, 1'b0);
    send_net(4'h6, 8'h40);
    results();
  end
endmodule : lnl_host_tb
